// ==== hw/mbw_slave_top.sv ====
// Command handler for write-multiple and read/write frames of a drive slave
`timescale 1ns/100ps
module mbw_slave_top #(
    parameter logic [19:0] GAP_CYC = mbw_pkg::GAP_CYCLES,
    parameter int FIFO_DEPTH = mbw_pkg::TX_FIFO_DEPTH
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [7:0] own_addr_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_valid_in,
    output logic [7:0] tx_data_out,
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    input wire logic [7:0] frequency_source_select_in,
    input wire logic [7:0] torque_reference_source_in,
    output logic param_req_out,
    output logic param_we_out,
    output logic [7:0] param_group_out,
    output logic [7:0] param_index_out,
    output logic [15:0] param_wdata_out,
    input wire logic param_ack_in,
    input wire logic [15:0] param_rdata_in,
    input wire logic [7:0] param_exc_in,
    output logic run_enable_out,
    output logic jog_out,
    output logic reverse_out,
    output logic stop_out,
    output logic estop_out,
    output logic fault_reset_out,
    output logic ramp_hold_out,
    output logic aux_active_out,
    output logic [15:0] freq_ref_out,
    output logic [15:0] torque_cmd_out
);
    import mbw_pkg::*;

    //------------------------------------------------------------------
    // State record
    //------------------------------------------------------------------
    typedef struct packed {
        mbw_state_e st;
        logic [19:0] gap;
        logic [5:0] len;
        logic [5:0] idx;
        logic [5:0] dpos;
        logic [4:0] k;
        logic [4:0] wcnt;
        logic [4:0] rcnt;
        logic [15:0] waddr;
        logic [15:0] raddr;
        logic [15:0] crc;
        logic ovf;
        logic [BUF_BYTES-1:0][7:0] fbuf;
        logic preq;
        logic pwe;
        logic [7:0] pgrp;
        logic [7:0] pidx;
        logic [15:0] pwd;
        logic [15:0] cmd;
        logic [15:0] freq;
        logic [15:0] torq;
    } mbw_slave_s;

    mbw_slave_s s;
    mbw_slave_s next_s;
    logic [7:0] fc;
    logic [15:0] wc16;
    logic [15:0] rc16;
    logic [15:0] wlast;
    logic [15:0] rlast;
    logic [5:0] hdr;
    logic [7:0] bc;
    logic [15:0] wa;
    logic [15:0] wd;
    logic [5:0] wi;
    logic [5:0] ri;
    logic wok;
    logic rok;
    logic cw_cmd;
    logic cw_freq;
    logic cw_torq;
    logic push;
    logic push_rdy;
    logic [7:0] push_byte;

    //------------------------------------------------------------------
    // Request field views
    //------------------------------------------------------------------
    // Field positions follow the master's request layout
    always_comb begin
        fc = s.fbuf[1];
        if (fc == FC_RWMULT) begin
            rc16 = {s.fbuf[4], s.fbuf[5]};
            wc16 = {s.fbuf[8], s.fbuf[9]};
            bc = s.fbuf[10];
            hdr = RW_HDR;
        end else begin
            rc16 = 16'h0000;
            wc16 = {s.fbuf[4], s.fbuf[5]};
            bc = s.fbuf[6];
            hdr = WM_HDR;
        end
        wlast = (fc == FC_RWMULT ? {s.fbuf[6], s.fbuf[7]} : {s.fbuf[2], s.fbuf[3]}) +
            wc16 - 16'h0001;
        rlast = {s.fbuf[2], s.fbuf[3]} + rc16 - 16'h0001;
    end

    // Address prechecks keep a frame from being half applied
    assign wok = (wlast[15:8] <= GRP_LAST && wa[15:8] <= GRP_LAST) ||
        (wa >= CTRL_CMD_ADDR && wlast <= CTRL_TORQ_ADDR);
    assign rok = (s.fbuf[2] <= GRP_LAST) && (rlast[15:8] <= GRP_LAST);

    // Word under service and its place in the buffer
    assign wi = s.dpos + {s.k, 1'b0};
    assign ri = RSP_DATA_POS + {s.k, 1'b0};
    assign wd = {s.fbuf[wi], s.fbuf[6'(wi + 6'h01)]};

    //------------------------------------------------------------------
    // Main sequencer
    //------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.preq = 1'b0;
        cw_cmd = 1'b0;
        cw_freq = 1'b0;
        cw_torq = 1'b0;
        push = 1'b0;
        push_byte = 8'h00;
        wa = (s.st == S_CHECK) ?
            (fc == FC_RWMULT ? {s.fbuf[6], s.fbuf[7]} : {s.fbuf[2], s.fbuf[3]}) :
            s.waddr + {11'h000, s.k};
        case (s.st)
            S_RX: begin
                // Bytes gather until the line has been idle for a full gap
                if (rx_valid_in) begin
                    next_s.gap = '0;
                    if (s.len < 6'(BUF_BYTES)) begin
                        next_s.fbuf[s.len] = rx_data_in;
                        next_s.len = s.len + 6'h01;
                        next_s.crc = mbw_crc_step(s.crc, rx_data_in);
                    end else begin
                        next_s.ovf = 1'b1;
                    end
                end else if (s.gap != GAP_CYC) begin
                    next_s.gap = s.gap + 20'h00001;
                end else if (s.len != 6'h00) begin
                    next_s.len = 6'h00;
                    next_s.crc = CRC_INIT;
                    next_s.ovf = 1'b0;
                    // Residue zero: check bytes arrived low first and match
                    if (!s.ovf && s.len >= MIN_FRAME && s.crc == 16'h0000 &&
                        s.fbuf[0] == own_addr_in) begin
                        next_s.len = s.len - 6'h02;
                        next_s.st = S_CHECK;
                    end
                end
            end
            S_CHECK: begin
                next_s.k = '0;
                next_s.idx = '0;
                next_s.waddr = wa;
                next_s.raddr = {s.fbuf[2], s.fbuf[3]};
                next_s.wcnt = wc16[4:0];
                next_s.rcnt = rc16[4:0];
                next_s.dpos = hdr;
                // An aborted write must not leave the wait state expecting an ack
                next_s.pwe = 1'b0;
                next_s.st = S_TX;
                next_s.len = EXC_LEN;
                next_s.fbuf[1] = fc | FC_EXC_FLAG;
                if (fc != FC_WMULT && fc != FC_RWMULT) begin
                    next_s.fbuf[2] = EXC_FUNC;
                end else if (wc16 == 16'h0000 || wc16 > {11'h000, MAX_WORDS} ||
                    (fc == FC_RWMULT && (rc16 == 16'h0000 || rc16 > {11'h000, MAX_WORDS})) ||
                    bc != {wc16[6:0], 1'b0} || s.len != hdr + bc[5:0]) begin
                    next_s.fbuf[2] = EXC_DATA;
                end else if (!wok || (fc == FC_RWMULT && !rok)) begin
                    next_s.fbuf[2] = EXC_ADDR;
                end else begin
                    next_s.fbuf[1] = fc;
                    next_s.st = S_WR;
                end
            end
            S_WR: begin
                if (wa[15:8] <= GRP_LAST) begin
                    // Range and run-lock checks live with the parameter store
                    next_s.preq = 1'b1;
                    next_s.pwe = 1'b1;
                    next_s.pgrp = wa[15:8];
                    next_s.pidx = wa[7:0];
                    next_s.pwd = wd;
                    next_s.st = S_WWAIT;
                end else begin
                    cw_cmd = (wa == CTRL_CMD_ADDR);
                    cw_freq = (wa == CTRL_FREQ_ADDR);
                    cw_torq = (wa == CTRL_TORQ_ADDR);
                    if (cw_cmd) begin
                        next_s.cmd = wd;
                    end
                    if (cw_freq && frequency_source_select_in == FREQ_SRC_COMM) begin
                        next_s.freq = wd;
                    end
                    if (cw_torq && torque_reference_source_in == TORQ_SRC_COMM) begin
                        next_s.torq = wd;
                    end
                    next_s.st = S_WWAIT;
                end
            end
            S_WWAIT: begin
                if (param_ack_in && param_exc_in != 8'h00) begin
                    next_s.fbuf[1] = fc | FC_EXC_FLAG;
                    next_s.fbuf[2] = param_exc_in;
                    next_s.len = EXC_LEN;
                    next_s.st = S_TX;
                end else if (param_ack_in || !s.pwe) begin
                    next_s.pwe = 1'b0;
                    next_s.k = s.k + 5'h01;
                    next_s.st = S_WR;
                    if (5'(s.k + 5'h01) == s.wcnt) begin
                        next_s.k = '0;
                        next_s.len = RSP_WM_LEN;
                        next_s.st = (fc == FC_RWMULT) ? S_RD : S_TX;
                    end
                end
            end
            S_RD: begin
                next_s.preq = 1'b1;
                next_s.pwe = 1'b0;
                next_s.pgrp = 8'(s.raddr + {11'h000, s.k} >> 8);
                next_s.pidx = 8'(s.raddr + {11'h000, s.k});
                next_s.st = S_RWAIT;
            end
            S_RWAIT: begin
                if (param_ack_in && param_exc_in != 8'h00) begin
                    next_s.fbuf[1] = fc | FC_EXC_FLAG;
                    next_s.fbuf[2] = param_exc_in;
                    next_s.len = EXC_LEN;
                    next_s.st = S_TX;
                end else if (param_ack_in) begin
                    // Read words reuse the buffer behind the reply header
                    next_s.fbuf[ri] = param_rdata_in[15:8];
                    next_s.fbuf[6'(ri + 6'h01)] = param_rdata_in[7:0];
                    next_s.k = s.k + 5'h01;
                    next_s.st = S_RD;
                    if (5'(s.k + 5'h01) == s.rcnt) begin
                        next_s.fbuf[2] = {2'b00, s.rcnt, 1'b0};
                        next_s.len = RSP_DATA_POS + {s.rcnt, 1'b0};
                        next_s.st = S_TX;
                    end
                end
            end
            S_TX: begin
                // Reply bytes, then check value low byte before high byte
                push = 1'b1;
                if (s.idx < s.len) begin
                    push_byte = s.fbuf[s.idx];
                end else if (s.idx == s.len) begin
                    push_byte = s.crc[7:0];
                end else begin
                    push_byte = s.crc[15:8];
                end
                if (push_rdy) begin
                    next_s.idx = s.idx + 6'h01;
                    if (s.idx < s.len) begin
                        next_s.crc = mbw_crc_step(s.crc, push_byte);
                    end
                    if (s.idx == 6'(s.len + 6'h01)) begin
                        next_s.st = S_RX;
                        next_s.idx = '0;
                        next_s.len = '0;
                        next_s.gap = '0;
                        next_s.crc = CRC_INIT;
                    end
                end
            end
            default: begin
                next_s.st = S_RX;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            s <= '0;
            s.crc <= CRC_INIT;
            s.cmd <= CMD_RESET;
        end else begin
            s <= next_s;
        end
    end

    //------------------------------------------------------------------
    // Reply buffer; a slow line stalls the sequencer, not the reply
    //------------------------------------------------------------------
    mbw_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .in_valid_in(push),
        .in_ready_out(push_rdy),
        .in_data_in(push_byte),
        .out_valid_out(tx_valid_out),
        .out_ready_in(tx_ready_in),
        .out_data_out(tx_data_out)
    );

    //------------------------------------------------------------------
    // Outputs from the state record
    //------------------------------------------------------------------
    assign param_req_out = s.preq;
    assign param_we_out = s.pwe;
    assign param_group_out = s.pgrp;
    assign param_index_out = s.pidx;
    assign param_wdata_out = s.pwd;
    assign run_enable_out = s.cmd[CMD_RUN];
    assign jog_out = s.cmd[CMD_JOG];
    assign reverse_out = s.cmd[CMD_REV];
    assign stop_out = s.cmd[CMD_STOP];
    assign estop_out = s.cmd[CMD_ESTOP];
    assign fault_reset_out = s.cmd[CMD_FRST];
    assign ramp_hold_out = s.cmd[CMD_RAMP];
    assign aux_active_out = !s.cmd[CMD_AUX_N];
    assign freq_ref_out = s.freq;
    assign torque_cmd_out = s.torq;

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);

    a_cmd_motion: assert property (cw_cmd |=> run_enable_out == $past(wd[0]) &&
        jog_out == $past(wd[1]) && reverse_out == $past(wd[2]))
        else $error("run, jog or direction not taken from command");
    a_cmd_stops: assert property (cw_cmd |=> stop_out == $past(wd[3]) &&
        estop_out == $past(wd[4]) && fault_reset_out == $past(wd[5]))
        else $error("stop bits not taken from command");
    a_cmd_ramp: assert property (cw_cmd |=> ramp_hold_out == $past(wd[6]) &&
        aux_active_out == !$past(wd[7]))
        else $error("ramp hold or active-low bit wrong");
    a_freq_gate: assert property (cw_freq |=> freq_ref_out ==
        ($past(frequency_source_select_in) == FREQ_SRC_COMM ? $past(wd) : $past(freq_ref_out)))
        else $error("frequency setpoint gate wrong");
    a_torq_gate: assert property (cw_torq |=> torque_cmd_out ==
        ($past(torque_reference_source_in) == TORQ_SRC_COMM ? $past(wd) : $past(torque_cmd_out)))
        else $error("torque setpoint gate wrong");
    a_gap_wait: assert property (s.st == S_RX && next_s.st == S_CHECK |-> s.gap == GAP_CYC)
        else $error("frame accepted before idle gap");
    a_group_range: assert property (param_req_out |-> param_group_out <= GRP_LAST)
        else $error("parameter group out of range");
    a_count_bound: assert property (s.st == S_WR |-> s.wcnt != 5'h00 && s.wcnt <= MAX_WORDS)
        else $error("write count outside one to sixteen");
    a_wm_reply: assert property ($rose(s.st == S_TX) && s.fbuf[1] == FC_WMULT |->
        s.len == RSP_WM_LEN)
        else $error("write reply length wrong");
    a_exc_reply: assert property ($rose(s.st == S_TX) && s.fbuf[1][7] |->
        s.len == EXC_LEN && s.fbuf[2] != 8'h00)
        else $error("exception reply malformed");
    a_rw_bytes: assert property ($rose(s.st == S_TX) && s.fbuf[1] == FC_RWMULT |->
        s.fbuf[2] == {2'b00, s.rcnt, 1'b0})
        else $error("read/write byte count wrong");

    c_wm_done: cover property ($rose(s.st == S_TX) && s.fbuf[1] == FC_WMULT);
    c_rw_done: cover property ($rose(s.st == S_TX) && s.fbuf[1] == FC_RWMULT);
    c_exc_done: cover property ($rose(s.st == S_TX) && s.fbuf[1][7]);
endmodule

// ==== hw/mbw_pkg.sv ====
// Constants, types and checksum step for the write-map command handler
//----------------------------------------------------------------------
// Overview of operation
// - Write-multiple carries one to sixteen registers
// - Write reply echoes address, code, start, count
// - Frames delimited by 3.5 character idle gap
// - Read/write carries one to sixteen each way
// - Read/write reply: byte count, read words
// - Parameter registers map one-to-one onto parameters
// - High byte group 0x00-0x0C, low byte index
// - Thirteen groups on consecutive codes 0x00-0x0C
// - Parameter index is zero based
// - Write-only command word at 0x4000
// - Bits 0-2: run, jog, reverse direction
// - Bits 3-5: stop, emergency stop, fault reset
// - Bit 6 ramp hold, bit 7 active low
// - Frequency setpoint applies only when source is 5
// - Torque setpoint applies only when source is 3
// - Failure reply: code plus 0x80, exception code
// - Exceptions 5 running, 3 address, 4 data
//----------------------------------------------------------------------
package mbw_pkg;

    //------------------------------------------------------------------
    // Function codes and exceptions
    //------------------------------------------------------------------
    localparam logic [7:0] FC_WMULT = 8'h10;
    localparam logic [7:0] FC_RWMULT = 8'h17;
    localparam logic [7:0] FC_EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_FUNC = 8'h02;
    localparam logic [7:0] EXC_ADDR = 8'h03;
    localparam logic [7:0] EXC_DATA = 8'h04;
    localparam logic [4:0] MAX_WORDS = 5'h10;

    //------------------------------------------------------------------
    // Register map
    //------------------------------------------------------------------
    localparam logic [7:0] GRP_LAST = 8'h0c;
    localparam logic [15:0] CTRL_CMD_ADDR = 16'h4000;
    localparam logic [15:0] CTRL_FREQ_ADDR = 16'h4001;
    localparam logic [15:0] CTRL_TORQ_ADDR = 16'h4002;
    localparam logic [7:0] FREQ_SRC_COMM = 8'h05;
    localparam logic [7:0] TORQ_SRC_COMM = 8'h03;
    localparam logic [15:0] CMD_RESET = 16'h0080;
    localparam int CMD_RUN = 0;
    localparam int CMD_JOG = 1;
    localparam int CMD_REV = 2;
    localparam int CMD_STOP = 3;
    localparam int CMD_ESTOP = 4;
    localparam int CMD_FRST = 5;
    localparam int CMD_RAMP = 6;
    localparam int CMD_AUX_N = 7;

    //------------------------------------------------------------------
    // Frame layout
    //------------------------------------------------------------------
    localparam int BUF_BYTES = 48;
    localparam logic [5:0] MIN_FRAME = 6'h04;
    localparam logic [5:0] WM_HDR = 6'h07;
    localparam logic [5:0] RW_HDR = 6'h0b;
    localparam logic [5:0] RSP_WM_LEN = 6'h06;
    localparam logic [5:0] EXC_LEN = 6'h03;
    localparam logic [5:0] RSP_DATA_POS = 6'h03;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam int TX_FIFO_DEPTH = 4;

    //------------------------------------------------------------------
    // Timing: 3.5 characters of 11 bits at the line rate
    //------------------------------------------------------------------
    localparam longint CLK_PERIOD_NS = 40;
    localparam longint BAUD = 9600;
    localparam longint CHAR_BITS = 11;
    localparam longint GAP_CHARS_X10 = 35;
    localparam longint GAP_TIME_NS = GAP_CHARS_X10 * CHAR_BITS * 64'd1000000000 / (10 * BAUD);
    localparam logic [19:0] GAP_CYCLES =
        20'((GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        S_RX = 3'b000,
        S_CHECK = 3'b001,
        S_WR = 3'b010,
        S_WWAIT = 3'b011,
        S_RD = 3'b100,
        S_RWAIT = 3'b101,
        S_TX = 3'b110
    } mbw_state_e;

    // One byte of the reflected CRC-16
    function automatic logic [15:0] mbw_crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

endpackage

// ==== hw/mbw_fifo.sv ====
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module mbw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    // Pointers wrap naturally, so DEPTH must be a power of two
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } mbw_fifo_s;

    mbw_fifo_s s;
    mbw_fifo_s next_s;
    logic wr;
    logic rd;

    // Honest flags straight from the fill count
    assign in_ready_out = (s.cnt != FULL);
    assign out_valid_out = (s.cnt != '0);
    assign out_data_out = s.mem[s.rp];

    // Push and pop bookkeeping
    always_comb begin
        next_s = s;
        wr = in_valid_in && in_ready_out;
        rd = out_ready_in && out_valid_out;
        if (wr) begin
            next_s.mem[s.wp] = in_data_in;
            next_s.wp = s.wp + 1'b1;
        end
        if (rd) begin
            next_s.rp = s.rp + 1'b1;
        end
        if (wr && !rd) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (rd && !wr) begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    a_fifo_hold: assert property (@(posedge core_clk_in) disable iff (reset_in)
        out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_data_out))
        else $error("fifo output changed while stalled");
endmodule

// ==== verification/mbw_master.sv ====
// Serial master station model: sends request frames and drains replies
`timescale 1ns/100ps
module mbw_master (
    input wire logic clk_in,
    input wire logic stall_in,
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    output logic tx_ready_out
);
    initial begin
        rx_data_out = 8'h00;
        rx_valid_out = 1'b0;
        tx_ready_out = 1'b0;
    end
    // Random back-pressure so the reply stream must hold under stalls
    always @(posedge clk_in) tx_ready_out <= !stall_in;
    // Reflected check value, seeded with all ones
    function automatic logic [15:0] crc(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    // One frame, check value low byte first; bad spoils the check value
    task automatic send(input logic [7:0] f[$], input logic bad);
        logic [15:0] c;
        c = crc(f) ^ {15'h0, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        foreach (f[i]) begin
            @(posedge clk_in);
            rx_data_out <= f[i];
            rx_valid_out <= 1'b1;
            @(posedge clk_in);
            rx_valid_out <= 1'b0;
            rx_data_out <= ~f[i];
        end
        repeat (30) @(posedge clk_in);
    endtask
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the write-map command handler
`timescale 1ns/100ps
module testbench;
    import mbw_pkg::*;
    logic clk = 0, rst = 1, rxv, txv, txr, req, we, ack = 0, stall = 0;
    logic [7:0] rxd, txd, grp, idx, pe = 0, fsrc = 8'h05, tsrc = 8'h03, cnt = 0;
    wire [7:0] ctl;
    logic [15:0] wd, rd = 0, fq, tq;
    logic [31:0] seed = 32'hc8ff8c73;
    logic [39:0] q[$];
    int mismatches = 0, n_compared = 0, cyc = 0;
    initial forever #20 clk = ~clk;
    mbw_master M (.clk_in(clk), .stall_in(stall), .rx_data_out(rxd), .rx_valid_out(rxv),
        .tx_ready_out(txr));
    mbw_slave_top #(.GAP_CYC(20'd20), .FIFO_DEPTH(4)) DUT (.core_clk_in(clk), .reset_in(rst),
        .own_addr_in(8'h01), .rx_data_in(rxd), .rx_valid_in(rxv), .tx_data_out(txd),
        .tx_valid_out(txv), .tx_ready_in(txr), .frequency_source_select_in(fsrc),
        .torque_reference_source_in(tsrc), .param_req_out(req), .param_we_out(we),
        .param_group_out(grp), .param_index_out(idx), .param_wdata_out(wd),
        .param_ack_in(ack), .param_rdata_in(rd), .param_exc_in(pe), .run_enable_out(ctl[0]),
        .jog_out(ctl[1]), .reverse_out(ctl[2]), .stop_out(ctl[3]), .estop_out(ctl[4]),
        .fault_reset_out(ctl[5]), .ramp_hold_out(ctl[6]), .aux_active_out(ctl[7]),
        .freq_ref_out(fq), .torque_cmd_out(tq));
    //------------------------------------------------------------------
    // Checking helpers
    //------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic rsp(input logic [7:0] b[$]);
        logic [15:0] c;
        c = M.crc(b);
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        foreach (b[i]) q.push_back({32'h0, b[i]});
    endtask
    task automatic pw(input logic w, input logic [31:0] p);
        q.push_back({7'h1, w, p});
    endtask
    task automatic run(input logic [7:0] f[$], input logic bad);
        M.send(f, bad);
        for (int i = 0; i < 3000 && q.size() != 0; i++) @(posedge clk);
        repeat (40) @(posedge clk);
    endtask
    task automatic wrap_up;
        if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Parameter store answers three cycles late; monitor takes notes in order
    always @(posedge clk) begin
        seed <= xs(seed);
        stall <= seed[3];
        cyc <= cyc + 1;
        if (req) cnt <= 8'd3;
        else if (cnt != 0) begin
            cnt <= cnt - 8'd1;
            rd <= {grp, idx};
        end
        ack <= !req && cnt == 8'd1;
        if (!rst && req)
            chk("param", {7'h1, we, grp, idx, we ? wd : 16'h0}, q.size() ? q.pop_front() : '1);
        if (!rst && txv && txr) chk("tx", {32'h0, txd}, q.size() ? q.pop_front() : '1);
        if (cyc == 20000) begin
            mismatches++;
            wrap_up;
        end
    end
    initial begin
        logic [15:0] v;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        pw(1, 32'h0109003c);
        pw(1, 32'h010a0050);
        rsp('{8'h01, 8'h10, 8'h01, 8'h09, 8'h00, 8'h02});
        run('{8'h01, 8'h10, 8'h01, 8'h09, 8'h00, 8'h02, 8'h04, 8'h00, 8'h3c, 8'h00, 8'h50}, 0);
        pw(1, 32'h01090064);
        pw(1, 32'h010a00c8);
        pw(0, 32'h0c000000);
        pw(0, 32'h0c010000);
        rsp('{8'h01, 8'h17, 8'h04, 8'h0c, 8'h00, 8'h0c, 8'h01});
        run('{8'h01, 8'h17, 8'h0c, 8'h00, 8'h00, 8'h02, 8'h01, 8'h09, 8'h00, 8'h02, 8'h04,
            8'h00, 8'h64, 8'h00, 8'hc8}, 0);
        v = seed[15:0];
        rsp('{8'h01, 8'h10, 8'h40, 8'h00, 8'h00, 8'h03});
        run('{8'h01, 8'h10, 8'h40, 8'h00, 8'h00, 8'h03, 8'h06, v[15:8], v[7:0], v[7:0], v[15:8],
            ~v[15:8], ~v[7:0]}, 0);
        chk("cmd", {32'h0, ctl}, {32'h0, ~v[7], v[6:0]});
        chk("set", {8'h0, fq, tq}, {8'h0, v[7:0], v[15:8], ~v});
        fsrc <= 8'h04;
        tsrc <= 8'h02;
        rsp('{8'h01, 8'h10, 8'h40, 8'h01, 8'h00, 8'h02});
        run('{8'h01, 8'h10, 8'h40, 8'h01, 8'h00, 8'h02, 8'h04, 8'h12, 8'h34, 8'h56, 8'h78}, 0);
        chk("hold", {8'h0, fq, tq}, {8'h0, v[7:0], v[15:8], ~v});
        rsp('{8'h01, 8'h90, 8'h04});
        run('{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
        rsp('{8'h01, 8'h90, 8'h03});
        run('{8'h01, 8'h10, 8'h0d, 8'h00, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34}, 0);
        pe <= 8'h05;
        pw(1, 32'h00001234);
        rsp('{8'h01, 8'h90, 8'h05});
        run('{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34}, 0);
        pe <= 8'h00;
        run('{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34}, 1);
        rsp('{8'h01, 8'h83, 8'h02});
        run('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 0);
        run('{8'h02, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34}, 0);
        wrap_up;
    end
endmodule
